// File: dcrb_map.vh
// Purpose: Register numbers, field positions and reset values of the
//          drive command register bank.
// Assumes: Word-addressed registers, sixteen bits wide.
// Notes:   Definitions only.
`ifndef DCRB_MAP_VH
`define DCRB_MAP_VH

`define DCRB_ADDR_W          16
`define DCRB_DATA_W          16
`define DCRB_IDX_W           4
`define DCRB_CMD_WINDOW      16'h0010
`define DCRB_REG_OPCMD       4'h1
`define DCRB_REG_FREQ        4'h2
`define DCRB_REG_GAIN        4'h3
`define DCRB_REG_LOOP        4'h6
`define DCRB_REG_AOUTA       4'h7
`define DCRB_REG_AOUTB       4'h8
`define DCRB_REG_DOUT        4'h9
`define DCRB_REG_SP2         4'hd
`define DCRB_REG_CSEL        4'hf
`define DCRB_MASK_OPCMD      16'h07ff
`define DCRB_MASK_DOUT       16'h00c7
`define DCRB_MASK_CSEL       16'h7012
`define DCRB_MASK_FULL       16'hffff
`define DCRB_RESET_WORD      16'h0000
`define DCRB_MAX_READ        5'h10
`define DCRB_BIT_RUN         0
`define DCRB_BIT_REV         1
`define DCRB_BIT_EXTF        2
`define DCRB_BIT_FRST        3
`define DCRB_BIT_MFI_LO      4
`define DCRB_BIT_MFI_HI      10
`define DCRB_BIT_DO1         0
`define DCRB_BIT_DO3         2
`define DCRB_BIT_FLT_EN      6
`define DCRB_BIT_FLT         7
`define DCRB_BIT_SP1_SEL     1
`define DCRB_BIT_SP2_SEL     4
`define DCRB_BIT_DI5_EN      12
`define DCRB_BIT_DI7_EN      14
`define DCRB_FN_REFERENCE_FROM_COMMS       8'h28
`define DCRB_FN_CONTROL_FROM_COMMS      8'h29
`define DCRB_BIT_MFI2        5
`define DCRB_BIT_DO2         1
`define DCRB_BIT_DI6_EN      13
`define DCRB_RESET_BIT       1'b0

`endif

// File: dcrb_word.v
// Purpose: One sixteen-bit command word with a writable-bit mask.
// Assumes: Synchronous active-high reset on mclk.
// Notes:   Bits outside the mask hold zero and read back as zero.
`timescale 1ns/1ps
`include "dcrb_map.vh"

module dcrb_word #(
    parameter [15:0] MASK = `DCRB_MASK_FULL
) (
    // Clock and reset.
    input  wire        mclk,
    input  wire        rst,
    // Write port.
    input  wire        wr_en,
    input  wire [15:0] wr_data,
    // Stored value.
    output reg  [15:0] value
);

    // Keep the last write until rewritten or reset; masked bits stay zero.
    always @(posedge mclk) begin
        if (rst) begin
            value <= `DCRB_RESET_WORD;
        end else if (wr_en) begin
            value <= wr_data & MASK;
        end
    end

endmodule

// File: dcrb_bank.v
// Purpose: Command-data register bank of a fan and pump drive.
// Assumes: The message engine on mclk presents one word per access with
//          the word already assembled high byte first.
// Notes:   Reads answer one cycle after the strobe from a register.
//          Run and communications selections are registered and follow
//          the stored command one cycle later; the other outputs show
//          the stored words directly.  Reserved numbers are tolerated
//          but never stored, so a stray write cannot disturb the drive.
`timescale 1ns/1ps
`include "dcrb_map.vh"

module dcrb_bank (
    // Clock and reset.
    input  wire        mclk,
    input  wire        rst,
    // Word access port from the message engine.
    input  wire        acc_wr,
    input  wire        acc_rd,
    input  wire [15:0] acc_addr,
    input  wire [15:0] acc_wdata,
    input  wire [4:0]  acc_count,
    output reg  [15:0] acc_rdata,
    output reg         acc_rvalid,
    output reg         acc_hit,
    output wire        acc_count_ok,
    // Drive parameters that steer decoding.
    input  wire        run_command_style_select,
    input  wire [7:0]  input_one_function_select,
    input  wire [7:0]  input_two_function_select,
    // Run commands towards motor control.
    output reg         run_forward,
    output reg         run_reverse,
    output wire        external_fault_request,
    output wire        fault_reset_request,
    output wire [6:0]  multi_function_inputs,
    output reg         reference_from_comms,
    output reg         control_from_comms,
    // Setpoints and references.
    output wire [15:0] frequency_reference,
    output wire [15:0] volts_per_hertz_gain,
    output wire [15:0] process_loop_target,
    output wire [15:0] analog_out_a,
    output wire [15:0] analog_out_b,
    output wire [15:0] second_loop_setpoint,
    // Contact outputs.
    output wire        contact_output_one,
    output wire        contact_output_two,
    output wire        contact_output_three,
    output wire        fault_override_active,
    output wire        fault_relay_contact,
    // Control selection.
    output wire        process_loop_from_comms,
    output wire        second_process_loop_from_comms,
    output wire        digital_input_five_broadcast,
    output wire        digital_input_six_broadcast,
    output wire        digital_input_seven_broadcast
);

    wire [15:0] opcmd;
    wire [15:0] dout;
    wire [15:0] csel;
    wire        in_win;
    wire [3:0]  idx;
    wire        mapped;
    wire        wr_opcmd;
    wire        wr_freq;
    wire        wr_gain;
    wire        wr_loop;
    wire        wr_aouta;
    wire        wr_aoutb;
    wire        wr_dout;
    wire        wr_sp2;
    wire        wr_csel;
    reg  [15:0] next_rdata;

    // Only the low sixteen numbers belong to the command window; the
    // monitor and broadcast maps above it live elsewhere in the drive.
    assign in_win = (acc_addr < `DCRB_CMD_WINDOW);
    assign idx    = acc_addr[`DCRB_IDX_W-1:0];

    // A read of more than sixteen words is flagged to the message engine.
    // The engine owns the error reply; this block only reports the limit.
    assign acc_count_ok = (acc_count <= `DCRB_MAX_READ);

    // One write enable per register.  Decoding them once here keeps the
    // storage instances short and makes each enable easy to probe.
    assign wr_opcmd = acc_wr && in_win && (idx == `DCRB_REG_OPCMD);
    assign wr_freq  = acc_wr && in_win && (idx == `DCRB_REG_FREQ);
    assign wr_gain  = acc_wr && in_win && (idx == `DCRB_REG_GAIN);
    assign wr_loop  = acc_wr && in_win && (idx == `DCRB_REG_LOOP);
    assign wr_aouta = acc_wr && in_win && (idx == `DCRB_REG_AOUTA);
    assign wr_aoutb = acc_wr && in_win && (idx == `DCRB_REG_AOUTB);
    assign wr_dout  = acc_wr && in_win && (idx == `DCRB_REG_DOUT);
    assign wr_sp2   = acc_wr && in_win && (idx == `DCRB_REG_SP2);
    assign wr_csel  = acc_wr && in_win && (idx == `DCRB_REG_CSEL);

    // Word storage, one instance per documented command register.  Each
    // instance clears its unwritable bits on the way in, so the read
    // path needs no masking and reserved bits always read as zero.
    // The enables above are exclusive, so at most one word changes.

    // Operation commands and multi-function inputs; the upper bits
    // are reserved and never stored.
    dcrb_word #(.MASK(`DCRB_MASK_OPCMD)) u_opcmd (
        .mclk    (mclk),
        .rst     (rst),
        .wr_en   (wr_opcmd),
        .wr_data (acc_wdata),
        .value   (opcmd)
    );

    // Frequency reference; its scaling is applied by motor control,
    // so the word is stored exactly as written.
    dcrb_word #(.MASK(`DCRB_MASK_FULL)) u_freq (
        .mclk    (mclk),
        .rst     (rst),
        .wr_en   (wr_freq),
        .wr_data (acc_wdata),
        .value   (frequency_reference)
    );

    // Voltage per frequency gain.
    dcrb_word #(.MASK(`DCRB_MASK_FULL)) u_gain (
        .mclk    (mclk),
        .rst     (rst),
        .wr_en   (wr_gain),
        .wr_data (acc_wdata),
        .value   (volts_per_hertz_gain)
    );

    // Process-loop target; the sign is kept, nothing here interprets it,
    // so all sixteen bits are stored.
    dcrb_word #(.MASK(`DCRB_MASK_FULL)) u_loop (
        .mclk    (mclk),
        .rst     (rst),
        .wr_en   (wr_loop),
        .wr_data (acc_wdata),
        .value   (process_loop_target)
    );

    // First analog output setting, handed unscaled to the converter.
    dcrb_word #(.MASK(`DCRB_MASK_FULL)) u_aouta (
        .mclk    (mclk),
        .rst     (rst),
        .wr_en   (wr_aouta),
        .wr_data (acc_wdata),
        .value   (analog_out_a)
    );

    // Second analog output setting, scaled the same way.
    dcrb_word #(.MASK(`DCRB_MASK_FULL)) u_aoutb (
        .mclk    (mclk),
        .rst     (rst),
        .wr_en   (wr_aoutb),
        .wr_data (acc_wdata),
        .value   (analog_out_b)
    );

    // Digital output settings; only the contact and fault bits stick,
    // so a careless master cannot set reserved outputs.
    dcrb_word #(.MASK(`DCRB_MASK_DOUT)) u_dout (
        .mclk    (mclk),
        .rst     (rst),
        .wr_en   (wr_dout),
        .wr_data (acc_wdata),
        .value   (dout)
    );

    // Second process-loop setpoint.
    dcrb_word #(.MASK(`DCRB_MASK_FULL)) u_sp2 (
        .mclk    (mclk),
        .rst     (rst),
        .wr_en   (wr_sp2),
        .wr_data (acc_wdata),
        .value   (second_loop_setpoint)
    );

    // Control selection; only the setpoint and broadcast enables stick.
    dcrb_word #(.MASK(`DCRB_MASK_CSEL)) u_csel (
        .mclk    (mclk),
        .rst     (rst),
        .wr_en   (wr_csel),
        .wr_data (acc_wdata),
        .value   (csel)
    );

    // Writes to reserved numbers are accepted and dropped; the engine
    // should not send them, so no error is raised here.
    assign mapped = in_win &&
                    (idx == `DCRB_REG_OPCMD || idx == `DCRB_REG_FREQ ||
                     idx == `DCRB_REG_GAIN  || idx == `DCRB_REG_LOOP ||
                     idx == `DCRB_REG_AOUTA || idx == `DCRB_REG_AOUTB ||
                     idx == `DCRB_REG_DOUT  || idx == `DCRB_REG_SP2  ||
                     idx == `DCRB_REG_CSEL);

    // Read multiplexer; reserved and unmapped numbers read as zero.
    // It looks only at the stored words, so a read in the same cycle as
    // a write to that register returns the value from before the write.
    always @* begin
        next_rdata = `DCRB_RESET_WORD;
        if (in_win) begin
            case (idx)
                `DCRB_REG_OPCMD: next_rdata = opcmd;
                `DCRB_REG_FREQ:  next_rdata = frequency_reference;
                `DCRB_REG_GAIN:  next_rdata = volts_per_hertz_gain;
                `DCRB_REG_LOOP:  next_rdata = process_loop_target;
                `DCRB_REG_AOUTA: next_rdata = analog_out_a;
                `DCRB_REG_AOUTB: next_rdata = analog_out_b;
                `DCRB_REG_DOUT:  next_rdata = dout;
                `DCRB_REG_SP2:   next_rdata = second_loop_setpoint;
                `DCRB_REG_CSEL:  next_rdata = csel;
                default:         next_rdata = `DCRB_RESET_WORD;
            endcase
        end
    end

    // Registered read answer, one cycle after the strobe.  The data is
    // held between reads so that the engine may take it late; only the
    // valid and hit flags are single-cycle pulses.
    always @(posedge mclk) begin
        if (rst) begin
            acc_rdata  <= `DCRB_RESET_WORD;
            acc_rvalid <= `DCRB_RESET_BIT;
            acc_hit    <= `DCRB_RESET_BIT;
        end else begin
            acc_rvalid <= acc_rd;
            acc_hit    <= (acc_rd || acc_wr) && mapped;
            if (acc_rd) begin
                acc_rdata <= next_rdata;
            end
        end
    end

    // Run decoding depends on the run style; registered so that a style
    // change and a command write never glitch the motor request.  The
    // cost is one cycle of latency, far below any motor time constant.
    always @(posedge mclk) begin
        if (rst) begin
            run_forward <= `DCRB_RESET_BIT;
            run_reverse <= `DCRB_RESET_BIT;
        end else if (run_command_style_select) begin
            run_forward <= opcmd[`DCRB_BIT_RUN] &
                           ~opcmd[`DCRB_BIT_REV];
            run_reverse <= opcmd[`DCRB_BIT_RUN] &
                           opcmd[`DCRB_BIT_REV];
        end else begin
            run_forward <= opcmd[`DCRB_BIT_RUN];
            run_reverse <= opcmd[`DCRB_BIT_REV];
        end
    end

    // Communications selections from inputs one and two.  Any other
    // function setting leaves the selection off, whatever the bit says.
    always @(posedge mclk) begin
        if (rst) begin
            reference_from_comms <= `DCRB_RESET_BIT;
            control_from_comms   <= `DCRB_RESET_BIT;
        end else begin
            reference_from_comms <= opcmd[`DCRB_BIT_MFI_LO] &&
                (input_one_function_select == `DCRB_FN_REFERENCE_FROM_COMMS);
            control_from_comms <= opcmd[`DCRB_BIT_MFI2] &&
                (input_two_function_select == `DCRB_FN_CONTROL_FROM_COMMS);
        end
    end

    // Direct command bits, shown straight from the stored word.
    // Motor control qualifies them; nothing here latches a fault.
    assign external_fault_request = opcmd[`DCRB_BIT_EXTF];
    assign fault_reset_request    = opcmd[`DCRB_BIT_FRST];
    assign multi_function_inputs  =
        opcmd[`DCRB_BIT_MFI_HI:`DCRB_BIT_MFI_LO];

    // Contact outputs; the fault relay is only overridden when enabled.
    // With the enable clear the relay stays with the drive's own logic.
    assign contact_output_one    = dout[`DCRB_BIT_DO1];
    assign contact_output_two    = dout[`DCRB_BIT_DO2];
    assign contact_output_three  = dout[`DCRB_BIT_DO3];
    assign fault_override_active = dout[`DCRB_BIT_FLT_EN];
    assign fault_relay_contact   = dout[`DCRB_BIT_FLT_EN] &
                                   dout[`DCRB_BIT_FLT];

    // Control selection enables.
    assign process_loop_from_comms        = csel[`DCRB_BIT_SP1_SEL];
    assign second_process_loop_from_comms = csel[`DCRB_BIT_SP2_SEL];
    assign digital_input_five_broadcast   = csel[`DCRB_BIT_DI5_EN];
    assign digital_input_six_broadcast    = csel[`DCRB_BIT_DI6_EN];
    assign digital_input_seven_broadcast  = csel[`DCRB_BIT_DI7_EN];

endmodule

// File: dcrb_monitor.sv
// Purpose: Concurrent checks on the command register bank ports.
// Assumes: One mclk domain, synchronous active-high rst.
// Notes:   Bound to every bank instance.
`timescale 1ns/1ps
module dcrb_monitor (
    // Clock, reset and access port.
    input wire        mclk,
    input wire        rst,
    input wire        acc_wr,
    input wire        acc_rd,
    input wire [15:0] acc_addr,
    input wire [15:0] acc_wdata,
    input wire [4:0]  acc_count,
    input wire [15:0] acc_rdata,
    input wire        acc_rvalid,
    input wire        acc_hit,
    input wire        acc_count_ok,
    // Decoded outputs.
    input wire [6:0]  multi_function_inputs,
    input wire [15:0] frequency_reference,
    input wire        fault_override_active,
    input wire        fault_relay_contact
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Reads answer exactly one cycle later, and only then.
    property p_rd_ans; acc_rd |=> acc_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read strobe got no answer");
    property p_no_ans; !acc_rd |=> !acc_rvalid; endproperty
    a_no_ans: assert property (p_no_ans)
        else $error("answer without a read");
    property p_hole;
        acc_rd && acc_addr > 16'h000f |=> acc_rdata == 16'h0000 && !acc_hit;
    endproperty
    a_hole: assert property (p_hole)
        else $error("unmapped read not zero");
    property p_hit; acc_rd && acc_addr == 16'h0002 |=> acc_hit; endproperty
    a_hit: assert property (p_hit)
        else $error("mapped read missed");
    property p_flt; fault_relay_contact |-> fault_override_active; endproperty
    a_flt: assert property (p_flt)
        else $error("fault contact without enable");
    property p_cnt; acc_count_ok == (acc_count <= 5'h10); endproperty
    a_cnt: assert property (p_cnt)
        else $error("read count limit wrong");
    property p_freq;
        acc_wr && acc_addr == 16'h0002
            |=> frequency_reference == $past(acc_wdata);
    endproperty
    a_freq: assert property (p_freq)
        else $error("frequency write lost");
    property p_mfi;
        acc_wr && acc_addr == 16'h0001
            |=> multi_function_inputs == $past(acc_wdata[10:4]);
    endproperty
    a_mfi: assert property (p_mfi)
        else $error("input bits write lost");
    c_flt: cover property (fault_relay_contact);
    c_hole: cover property (acc_rd && acc_addr > 16'h000f);
    c_big: cover property (acc_rd && !acc_count_ok);
endmodule
bind dcrb_bank dcrb_monitor i_dcrb_monitor (.*);

// File: dcrb_master.sv
// Purpose: Serial bus master model giving one word access at a time.
// Assumes: Strobes rise just after an mclk edge and last one cycle.
// Notes:   Released address and data lines show inverted junk.
`timescale 1ns/1ps
module dcrb_master (
    // Clock and read answer.
    input  wire        mclk,
    input  wire [15:0] acc_rdata,
    input  wire        acc_rvalid,
    // Access request.
    output reg         acc_wr = 1'h0,
    output reg         acc_rd = 1'h0,
    output reg  [15:0] acc_addr = 16'h0000,
    output reg  [15:0] acc_wdata = 16'h0000,
    output reg  [4:0]  acc_count = 5'h00
);
    // Write one word; an idle cycle follows so strobes never collide.
    task wr(input [15:0] a, input [15:0] v);
        begin
            acc_wr <= 1'h1;
            acc_addr <= a;
            acc_wdata <= v;
            @(posedge mclk);
            acc_wr <= 1'h0;
            acc_addr <= ~a;
            acc_wdata <= ~v;
            @(posedge mclk);
        end
    endtask
    // Read one word; the answer is taken at the second edge.
    task rd(input [15:0] a, input [4:0] n, output [15:0] v, output ok);
        begin
            acc_rd <= 1'h1;
            acc_addr <= a;
            acc_count <= n;
            @(posedge mclk);
            acc_rd <= 1'h0;
            acc_addr <= ~a;
            @(posedge mclk);
            v = acc_rdata;
            ok = acc_rvalid;
        end
    endtask
endmodule

// File: dcrb_bank_tb.sv
// Purpose: Random and corner tests of the command register bank.
// Assumes: The master model drives the word access port.
// Notes:   Expected values come from a shadow copy of the registers.
`timescale 1ns/1ps
module dcrb_bank_tb;
    reg mclk = 1'h0, rst = 1'h1, run_command_style_select = 1'h0;
    reg [7:0] input_one_function_select = 8'h00;
    reg [7:0] input_two_function_select = 8'h00;
    reg [4:0] sel;
    reg [15:0] r [0:15];
    reg [15:0] d, q, c;
    wire acc_wr, acc_rd, acc_rvalid, acc_hit, acc_count_ok, run_forward;
    wire run_reverse, external_fault_request, fault_reset_request;
    wire reference_from_comms, control_from_comms, contact_output_one;
    wire contact_output_two, contact_output_three, fault_override_active;
    wire fault_relay_contact, process_loop_from_comms;
    wire second_process_loop_from_comms, digital_input_five_broadcast;
    wire digital_input_six_broadcast, digital_input_seven_broadcast;
    wire [15:0] acc_addr, acc_wdata, acc_rdata, frequency_reference;
    wire [15:0] volts_per_hertz_gain, process_loop_target, analog_out_a;
    wire [15:0] analog_out_b, second_loop_setpoint;
    wire [4:0] acc_count;
    wire [6:0] multi_function_inputs;
    integer n_errors = 0, compares = 0, cyc = 0, i;
    dcrb_bank i_dcrb_bank (.*);
    dcrb_master i_dcrb_master (.*);
    always #2.5 mclk = ~mclk;
    // A hang counts as a mismatch and still reaches the report.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors = n_errors + 1;
            print_verdict;
        end
    end
    task chk(input string what, input [15:0] seen, input [15:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected %s: expected %h, seen %h",
                         what, exp, seen);
            end
        end
    endtask
    // Writable bits of each register; holes keep nothing.
    function [15:0] msk(input [4:0] a);
        case (a)
            5'h01: msk = 16'h07ff;
            5'h09: msk = 16'h00c7;
            5'h0f: msk = 16'h7012;
            5'h02, 5'h03, 5'h06, 5'h07, 5'h08, 5'h0d: msk = 16'hffff;
            default: msk = 16'h0000;
        endcase
    endfunction
    task put(input [4:0] a, input [15:0] v);
        begin
            i_dcrb_master.wr({11'h000, a}, v);
            if (!a[4]) r[a[3:0]] = v & msk(a);
        end
    endtask
    task get(input [4:0] a);
        reg [15:0] v;
        reg ok;
        begin
            i_dcrb_master.rd({11'h000, a}, $urandom, v, ok);
            chk("read_valid", {15'h0000, ok}, 16'h0001);
            chk("read_data", v, a[4] ? 16'h0000 : r[a[3:0]]);
            chk("read_hit", {15'h0000, acc_hit},
                {15'h0000, msk(a) != 16'h0000});
            chk("count_ok", {15'h0000, acc_count_ok},
                {15'h0000, acc_count <= 5'h10});
        end
    endtask
    // Run and comms outputs settle one cycle after the register, so one edge is waited.
    task outs;
        begin
            @(posedge mclk);
            d = r[1];
            q = r[9];
            c = r[15];
            chk("run", {run_forward, run_reverse},
                run_command_style_select ? {d[0] & ~d[1], d[0] & d[1]}
                                         : {d[0], d[1]});
            chk("comms", {reference_from_comms, control_from_comms},
                {d[4] && input_one_function_select == 8'h28,
                 d[5] && input_two_function_select == 8'h29});
            chk("inputs", multi_function_inputs, d[10:4]);
            chk("faults", {external_fault_request, fault_reset_request},
                {d[2], d[3]});
            chk("freq", frequency_reference, r[2]);
            chk("gain", volts_per_hertz_gain, r[3]);
            chk("loop", process_loop_target, r[6]);
            chk("aouts", analog_out_a ^ analog_out_b, r[7] ^ r[8]);
            chk("aout_a", analog_out_a, r[7]);
            chk("sp2", second_loop_setpoint, r[13]);
            chk("contacts", {contact_output_three, contact_output_two,
                contact_output_one}, q[2:0]);
            chk("fault",
                {fault_override_active, fault_relay_contact},
                {q[6], q[6] & q[7]});
            chk("csel",
                {process_loop_from_comms, second_process_loop_from_comms,
                 digital_input_seven_broadcast, digital_input_six_broadcast,
                 digital_input_five_broadcast}, {c[1], c[4], c[14:12]});
        end
    endtask
    task print_verdict;
        begin
            $display("n_errors %0d compares %0d", n_errors, compares);
            if (n_errors == 0 && compares > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        d = $urandom(16);
        for (i = 0; i < 16; i = i + 1) r[i] = 16'h0000;
        repeat (6) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        // Reset contents, then all ones everywhere including the holes.
        for (i = 0; i < 32; i = i + 1) get(i);
        for (i = 0; i < 32; i = i + 1) put(i, 16'hffff);
        outs;
        for (i = 0; i < 32; i = i + 1) get(i);
        for (i = 0; i < 400; i = i + 1) begin
            run_command_style_select <= $urandom;
            input_one_function_select <= $urandom % 2 ? 8'h28 : $urandom;
            input_two_function_select <= $urandom % 2 ? 8'h29 : $urandom;
            // Random writes keep the master's side: mapped registers
            // only, with every unused bit written as zero.
            sel = $urandom % 16;
            if (msk(sel) == 16'h0000) sel = 5'h02;
            put(sel, $urandom & msk(sel));
            outs;
            get($urandom);
        end
        // A second reset in mid-run clears every register.
        rst <= 1'h1;
        @(posedge mclk);
        rst <= 1'h0;
        for (i = 0; i < 16; i = i + 1) r[i] = 16'h0000;
        outs;
        for (i = 0; i < 16; i = i + 1) get(i);
        print_verdict;
    end
endmodule
